// >>> rtl/l1c_pkg.sv
// Constants and carrier types for the split L1 instruction and data caches.
// Assumes one core clock and a word-wide system bus answering per beat.
package l1c_pkg;

  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int TAG_W = 22;
  localparam int SET_W = 6;
  localparam int SETS = 64;
  localparam int LINE_WORDS = 4;
  localparam int LINE_BYTES = 16;
  localparam int WAY_IDX_W = 4;
  localparam int MAX_WAYS = 16;
  localparam int WORD_LSB = 2;
  localparam int SET_LSB = 4;
  localparam int TAG_LSB = 10;
  localparam int IC_BYTES = 16384;
  localparam int DC_BYTES = 4096;
  localparam logic [1:0] LAST_BEAT = 2'h3;
  localparam logic SEL_I = 1'b0;
  localparam logic SEL_D = 1'b1;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef enum logic [1:0] {
    L1C_OP_LOAD = 2'h0,
    L1C_OP_STORE = 2'h1,
    L1C_OP_LOCK = 2'h2,
    L1C_OP_UNLOCK = 2'h3
  } l1c_op_t;

  typedef struct packed {
    logic valid;
    l1c_op_t op;
    logic [31:0] vaddr;
    logic [TAG_W-1:0] ptag;
    logic [31:0] wdata;
    logic [3:0] wstrb;
  } l1c_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] rdata;
  } l1c_rsp_t;

  typedef struct packed {
    logic valid;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
  } l1c_bus_t;

  typedef struct packed {
    logic valid;
    logic lock;
    logic [TAG_W-1:0] tag;
  } l1c_tag_t;

  typedef enum logic [2:0] {
    L1C_IDLE = 3'h0,
    L1C_LOOK = 3'h1,
    L1C_FILL = 3'h3,
    L1C_WBACK = 3'h2,
    L1C_WTHRU = 3'h4
  } l1c_fsm_t;

  typedef struct packed {
    l1c_fsm_t fsm;
    logic sel;
    l1c_req_t req;
    logic [1:0] beat;
    logic [WAY_IDX_W-1:0] way;
    logic alloc;
    logic lfb_vld;
    logic [SET_W-1:0] lfb_set;
    logic [TAG_W-1:0] lfb_tag;
    logic [LINE_WORDS-1:0][31:0] lfb_data;
    l1c_rsp_t i_rsp;
    l1c_rsp_t d_rsp;
    l1c_bus_t bus;
  } l1c_state_t;

  function automatic logic [31:0] l1c_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
    l1c_merge = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        l1c_merge[8*b +: 8] = wd[8*b +: 8];
      end
    end
  endfunction : l1c_merge

endpackage : l1c_pkg

// >>> rtl/l1c_victim.sv
// Replacement choice and age update for one cache set.
// Assumes ages form a permutation of 0..WAYS-1; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module l1c_victim
  import l1c_pkg::*;
#(
  parameter int WAYS = 4
) (
  // Way status
  input wire logic [WAYS-1:0] valid_i,
  input wire logic [WAYS-1:0] lock_i,
  input wire logic [WAYS*$clog2(WAYS)-1:0] age_i,
  // Choice and update
  input wire logic [WAY_IDX_W-1:0] touch_i,
  output logic [WAY_IDX_W-1:0] victim_o,
  output logic none_o,
  output logic [WAYS*$clog2(WAYS)-1:0] age_o
);
  localparam int AW = $clog2(WAYS);

  if (WAYS < 2 || WAYS > MAX_WAYS || (WAYS & (WAYS - 1)) != 0) begin : g_chk
    $error("l1c_victim: WAYS must be a power of two from 2 to 16");
  end

  logic [AW-1:0] touch_age;
  logic [AW-1:0] best;
  logic inv;

  assign touch_age = age_i[int'(touch_i[AW-1:0])*AW +: AW];

  // ----------------------------------------
  // Touched way becomes youngest
  // ----------------------------------------
  for (genvar w = 0; w < WAYS; w++) begin : g_age
    always_comb begin
      if (touch_i[AW-1:0] == AW'(w)) begin
        age_o[w*AW +: AW] = '0;
      end else if (age_i[w*AW +: AW] < touch_age) begin
        age_o[w*AW +: AW] = AW'(age_i[w*AW +: AW] + 1'b1);
      end else begin
        age_o[w*AW +: AW] = age_i[w*AW +: AW];
      end
    end
  end

  // ----------------------------------------
  // Empty way first, else oldest unlocked
  // ----------------------------------------
  always_comb begin
    victim_o = '0;
    none_o = 1'b1;
    best = '0;
    inv = 1'b0;
    for (int w = 0; w < WAYS; w++) begin
      if (!valid_i[w] && !inv) begin
        victim_o = WAY_IDX_W'(w);
        none_o = 1'b0;
        inv = 1'b1;
      end else if (!inv && valid_i[w] && !lock_i[w] &&
                   (none_o || age_i[w*AW +: AW] >= best)) begin
        victim_o = WAY_IDX_W'(w);
        best = age_i[w*AW +: AW];
        none_o = 1'b0;
      end
    end
  end

endmodule : l1c_victim
`default_nettype wire

// >>> rtl/l1c_top.sv
// Split L1 caches: instruction and data, virtually indexed, physically tagged.
// Assumes translation supplies the physical tag with each request, same clock.
`timescale 1ns/1ps
`default_nettype none
module l1c_top
  import l1c_pkg::*;
#(
  parameter int IC_CAP = IC_BYTES,
  parameter int DC_CAP = DC_BYTES
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Fetch port
  input wire l1c_req_t i_req_i,
  output logic i_ready_o,
  output l1c_rsp_t i_rsp_o,
  // Load/store port
  input wire l1c_req_t d_req_i,
  output logic d_ready_o,
  output l1c_rsp_t d_rsp_o,
  // System bus
  output l1c_bus_t bus_req_o,
  input wire logic bus_ack_i,
  input wire logic [31:0] bus_rdata_i
);
  localparam int IC_WAYS = IC_CAP / (SETS * LINE_BYTES);
  localparam int DC_WAYS = DC_CAP / (SETS * LINE_BYTES);
  localparam int IC_AW = $clog2(IC_WAYS);
  localparam int DC_AW = $clog2(DC_WAYS);
  localparam int DC_AGE_W = DC_WAYS * DC_AW;

  if (IC_CAP % (SETS * LINE_BYTES) != 0 || DC_CAP % (SETS * LINE_BYTES) != 0) begin : g_chk
    $error("l1c_top: capacity must be whole ways of one kilobyte");
  end

  // ----------------------------------------
  // Arrays
  // ----------------------------------------
  l1c_tag_t ic_tag_mem [IC_WAYS*SETS];
  logic [31:0] ic_dat_mem [IC_WAYS*SETS*LINE_WORDS];
  logic [IC_WAYS*IC_AW-1:0] ic_age_mem [SETS];
  l1c_tag_t dc_tag_mem [DC_WAYS*SETS];
  logic [31:0] dc_dat_mem [DC_WAYS*SETS*LINE_WORDS];
  logic [DC_WAYS+DC_AGE_W-1:0] dc_meta_mem [SETS];

  l1c_state_t r, n;
  logic [SET_W-1:0] set;
  logic [1:0] woff;
  logic [IC_WAYS-1:0] ic_vld, ic_lck, ic_hitv;
  logic [DC_WAYS-1:0] dc_vld, dc_lck, dc_hitv, dc_dirty, dirty_n;
  logic [WAY_IDX_W-1:0] ic_hway, dc_hway, ic_vic, dc_vic, hway, vic, mem_way;
  logic ic_none, dc_none, none, hit, vdirty, lfb_hit, lfb_path;
  logic [IC_WAYS*IC_AW-1:0] ic_age_n;
  logic [DC_AGE_W-1:0] dc_age_n;
  int i_hidx, d_hidx, d_vidx, i_widx, d_widx;
  logic [31:0] hword, word_w, ans_d;
  l1c_tag_t hit_ent, tag_w;
  logic [LINE_WORDS-1:0][31:0] line_w;
  logic ans, tag_we, age_we, word_we, line_we, dirty_we, dirty_v;

  // index from the virtual address, tag from the translated one
  assign set = r.req.vaddr[SET_LSB +: SET_W];
  assign woff = r.req.vaddr[WORD_LSB +: 2];

  // ----------------------------------------
  // Tag compare
  // ----------------------------------------
  for (genvar w = 0; w < IC_WAYS; w++) begin : g_ic
    assign ic_vld[w] = ic_tag_mem[int'(set)*IC_WAYS + w].valid;
    assign ic_lck[w] = ic_tag_mem[int'(set)*IC_WAYS + w].lock;
    assign ic_hitv[w] = ic_vld[w] && ic_tag_mem[int'(set)*IC_WAYS + w].tag == r.req.ptag;
  end
  for (genvar w = 0; w < DC_WAYS; w++) begin : g_dc
    assign dc_vld[w] = dc_tag_mem[int'(set)*DC_WAYS + w].valid;
    assign dc_lck[w] = dc_tag_mem[int'(set)*DC_WAYS + w].lock;
    assign dc_hitv[w] = dc_vld[w] && dc_tag_mem[int'(set)*DC_WAYS + w].tag == r.req.ptag;
  end

  always_comb begin
    ic_hway = '0;
    dc_hway = '0;
    for (int w = 0; w < IC_WAYS; w++) begin
      if (ic_hitv[w]) begin
        ic_hway = WAY_IDX_W'(w);
      end
    end
    for (int w = 0; w < DC_WAYS; w++) begin
      if (dc_hitv[w]) begin
        dc_hway = WAY_IDX_W'(w);
      end
    end
  end

  l1c_victim #(.WAYS(IC_WAYS)) u_ic_vic (
    .valid_i(ic_vld),
    .lock_i(ic_lck),
    .age_i(ic_age_mem[set]),
    .touch_i(mem_way),
    .victim_o(ic_vic),
    .none_o(ic_none),
    .age_o(ic_age_n)
  );
  l1c_victim #(.WAYS(DC_WAYS)) u_dc_vic (
    .valid_i(dc_vld),
    .lock_i(dc_lck),
    .age_i(dc_meta_mem[set][DC_AGE_W-1:0]),
    .touch_i(mem_way),
    .victim_o(dc_vic),
    .none_o(dc_none),
    .age_o(dc_age_n)
  );

  assign dc_dirty = dc_meta_mem[set][DC_AGE_W +: DC_WAYS];
  assign hit = r.sel ? |dc_hitv : |ic_hitv;
  assign hway = r.sel ? dc_hway : ic_hway;
  assign vic = r.sel ? dc_vic : ic_vic;
  assign none = r.sel ? dc_none : ic_none;
  assign vdirty = r.sel && dc_vld[dc_vic[DC_AW-1:0]] && dc_dirty[dc_vic[DC_AW-1:0]];
  assign i_hidx = int'(set)*IC_WAYS + int'(ic_hway);
  assign d_hidx = int'(set)*DC_WAYS + int'(dc_hway);
  assign d_vidx = int'(set)*DC_WAYS + int'(r.fsm == L1C_LOOK ? dc_vic : r.way);
  assign i_widx = int'(set)*IC_WAYS + int'(mem_way);
  assign d_widx = int'(set)*DC_WAYS + int'(mem_way);
  assign hword = r.sel ? dc_dat_mem[d_hidx*LINE_WORDS + int'(woff)]
                       : ic_dat_mem[i_hidx*LINE_WORDS + int'(woff)];
  assign hit_ent = r.sel ? dc_tag_mem[d_hidx] : ic_tag_mem[i_hidx];
  assign lfb_hit = r.lfb_vld && r.lfb_set == set && r.lfb_tag == r.req.ptag;
  assign lfb_path = lfb_hit && r.sel == SEL_I && r.req.op == L1C_OP_LOAD;

  // ----------------------------------------
  // Controller
  // ----------------------------------------
  always_comb begin
    n = r;
    n.i_rsp.valid = 1'b0;
    n.d_rsp.valid = 1'b0;
    ans = 1'b0;
    ans_d = '0;
    tag_we = 1'b0;
    tag_w = hit_ent;
    age_we = 1'b0;
    word_we = 1'b0;
    line_we = 1'b0;
    dirty_we = 1'b0;
    dirty_v = 1'b0;
    mem_way = hway;
    word_w = l1c_merge(hword, r.req.wdata, r.req.wstrb);
    line_w = r.lfb_data;
    line_w[r.beat] = bus_rdata_i;
    if (r.req.op == L1C_OP_STORE) begin
      line_w[woff] = l1c_merge(line_w[woff], r.req.wdata, r.req.wstrb);
    end
    unique case (r.fsm)
      L1C_IDLE: begin
        if (d_req_i.valid) begin
          n.sel = SEL_D;
          n.req = d_req_i;
          n.fsm = L1C_LOOK;
        end else if (i_req_i.valid) begin
          n.sel = SEL_I;
          n.req = i_req_i;
          if (i_req_i.op == L1C_OP_STORE) begin
            n.req.op = L1C_OP_LOAD;
          end
          n.fsm = L1C_LOOK;
        end
      end
      L1C_LOOK: begin
        n.fsm = L1C_IDLE;
        n.beat = '0;
        if (lfb_path) begin
          ans = 1'b1;
          ans_d = r.lfb_data[woff];
        end else if (hit) begin
          ans = 1'b1;
          unique case (r.req.op)
            L1C_OP_LOAD: begin
              ans_d = hword;
              age_we = 1'b1;
            end
            L1C_OP_STORE: begin
              word_we = 1'b1;
              age_we = 1'b1;
              dirty_we = 1'b1;
              dirty_v = 1'b1;
            end
            default: begin
              tag_we = 1'b1;
              tag_w.lock = r.req.op == L1C_OP_LOCK;
            end
          endcase
        end else if (r.req.op == L1C_OP_UNLOCK) begin
          ans = 1'b1;
        end else begin
          n.alloc = !none;
          n.way = vic;
          n.lfb_vld = 1'b0;
          n.bus.valid = 1'b1;
          n.bus.we = 1'b0;
          n.bus.wstrb = '0;
          n.bus.addr = {r.req.ptag, set, 4'h0};
          n.fsm = L1C_FILL;
          if (none && r.req.op == L1C_OP_STORE) begin
            n.bus.we = 1'b1;
            n.bus.addr = {r.req.ptag, r.req.vaddr[TAG_LSB-1:WORD_LSB], 2'h0};
            n.bus.wdata = r.req.wdata;
            n.bus.wstrb = r.req.wstrb;
            n.fsm = L1C_WTHRU;
          end else if (!none && vdirty) begin
            n.bus.we = 1'b1;
            n.bus.addr = {dc_tag_mem[d_vidx].tag, set, 4'h0};
            n.bus.wdata = dc_dat_mem[d_vidx*LINE_WORDS];
            n.bus.wstrb = '1;
            n.fsm = L1C_WBACK;
          end
        end
      end
      L1C_WBACK: begin
        if (bus_ack_i) begin
          n.beat = r.beat + 2'h1;
          n.bus.addr[SET_LSB-1:WORD_LSB] = r.beat + 2'h1;
          n.bus.wdata = dc_dat_mem[d_vidx*LINE_WORDS + int'(n.beat)];
          if (r.beat == LAST_BEAT) begin
            n.bus.we = 1'b0;
            n.bus.wstrb = '0;
            n.bus.addr = {r.req.ptag, set, 4'h0};
            n.fsm = L1C_FILL;
          end
        end
      end
      L1C_FILL: begin
        if (bus_ack_i) begin
          n.lfb_data[r.beat] = bus_rdata_i;
          n.beat = r.beat + 2'h1;
          n.bus.addr[SET_LSB-1:WORD_LSB] = r.beat + 2'h1;
          if (r.beat == woff && r.req.op == L1C_OP_LOAD) begin
            ans = 1'b1;
            ans_d = bus_rdata_i;
          end
          if (r.beat == LAST_BEAT) begin
            n.bus.valid = 1'b0;
            n.fsm = L1C_IDLE;
            n.lfb_vld = r.sel == SEL_I;
            n.lfb_set = set;
            n.lfb_tag = r.req.ptag;
            ans = ans || r.req.op != L1C_OP_LOAD;
            if (r.alloc) begin
              mem_way = r.way;
              line_we = 1'b1;
              tag_we = 1'b1;
              tag_w = '{valid: 1'b1, lock: r.req.op == L1C_OP_LOCK, tag: r.req.ptag};
              age_we = 1'b1;
              dirty_we = 1'b1;
              dirty_v = r.req.op == L1C_OP_STORE;
            end
          end
        end
      end
      L1C_WTHRU: begin
        if (bus_ack_i) begin
          n.bus.valid = 1'b0;
          ans = 1'b1;
          n.fsm = L1C_IDLE;
        end
      end
      default: n.fsm = L1C_IDLE;
    endcase
    if (ans && r.sel == SEL_D) begin
      n.d_rsp.valid = 1'b1;
      n.d_rsp.rdata = ans_d;
    end
    if (ans && r.sel == SEL_I) begin
      n.i_rsp.valid = 1'b1;
      n.i_rsp.rdata = ans_d;
    end
    dirty_n = dc_dirty;
    if (dirty_we) begin
      dirty_n[mem_way[DC_AW-1:0]] = dirty_v;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------
  // Array writes
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < IC_WAYS*SETS; i++) begin
        ic_tag_mem[i] <= '0;
      end
      for (int i = 0; i < DC_WAYS*SETS; i++) begin
        dc_tag_mem[i] <= '0;
      end
      for (int s = 0; s < SETS; s++) begin
        dc_meta_mem[s] <= '0;
        for (int w = 0; w < IC_WAYS; w++) begin
          ic_age_mem[s][w*IC_AW +: IC_AW] <= IC_AW'(w);
        end
        for (int w = 0; w < DC_WAYS; w++) begin
          dc_meta_mem[s][w*DC_AW +: DC_AW] <= DC_AW'(w);
        end
      end
    end else begin
      if (tag_we && r.sel == SEL_I) ic_tag_mem[i_widx] <= tag_w;
      if (tag_we && r.sel == SEL_D) dc_tag_mem[d_widx] <= tag_w;
      if (age_we && r.sel == SEL_I) ic_age_mem[set] <= ic_age_n;
      if (age_we && r.sel == SEL_D) dc_meta_mem[set] <= {dirty_n, dc_age_n};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (word_we && r.sel == SEL_D) dc_dat_mem[d_widx*LINE_WORDS + int'(woff)] <= word_w;
    for (int k = 0; k < LINE_WORDS; k++) begin
      if (line_we && r.sel == SEL_D) dc_dat_mem[d_widx*LINE_WORDS + k] <= line_w[k];
      if (line_we && r.sel == SEL_I) ic_dat_mem[i_widx*LINE_WORDS + k] <= line_w[k];
    end
  end

  assign i_ready_o = r.fsm == L1C_IDLE && !d_req_i.valid;
  assign d_ready_o = r.fsm == L1C_IDLE;
  assign i_rsp_o = r.i_rsp;
  assign d_rsp_o = r.d_rsp;
  assign bus_req_o = r.bus;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_lfb_bypass: assert property (r.fsm == L1C_LOOK && lfb_path
    |=> i_rsp_o.valid && i_rsp_o.rdata == r.lfb_data[$past(woff)])
    else $error("fill buffer bypass not answered");
  a_crit_word: assert property (r.fsm == L1C_FILL && bus_ack_i && r.beat == woff
    && r.req.op == L1C_OP_LOAD |=> (i_rsp_o.valid || d_rsp_o.valid)
    && (r.sel ? d_rsp_o.rdata : i_rsp_o.rdata) == $past(bus_rdata_i))
    else $error("critical word not passed from bus");
  a_vipt_addr: assert property (r.fsm == L1C_FILL && bus_req_o.valid
    |-> bus_req_o.addr[31:TAG_LSB] == r.req.ptag && bus_req_o.addr[TAG_LSB-1:SET_LSB] == set)
    else $error("fill address not from tag and index");
  a_tag_alloc: assert property (r.fsm == L1C_FILL && bus_ack_i && r.beat == LAST_BEAT
    && r.alloc && r.sel == SEL_I |=> ic_tag_mem[$past(i_widx)].valid
    && ic_tag_mem[$past(i_widx)].tag == $past(r.req.ptag))
    else $error("filled tag entry wrong");
  a_age_touch: assert property (r.fsm == L1C_LOOK && !lfb_path && hit
    && r.sel == SEL_I && r.req.op == L1C_OP_LOAD
    |=> ic_age_mem[$past(set)][$past(i_hidx) % IC_WAYS * IC_AW +: IC_AW] == '0)
    else $error("hit way not made youngest");
  a_ilock_set: assert property (r.fsm == L1C_LOOK && hit && r.sel == SEL_I
    && r.req.op == L1C_OP_LOCK |=> ic_tag_mem[$past(i_hidx)].lock && i_rsp_o.valid)
    else $error("instruction lock not set");
  a_dlock_clr: assert property (r.fsm == L1C_LOOK && hit && r.sel == SEL_D
    && r.req.op == L1C_OP_UNLOCK |=> !dc_tag_mem[$past(d_hidx)].lock && d_rsp_o.valid)
    else $error("data unlock not cleared");
  a_store_hit: assert property (r.fsm == L1C_LOOK && hit && r.sel == SEL_D
    && r.req.op == L1C_OP_STORE |=> dc_dat_mem[$past(d_hidx)*LINE_WORDS + $past(woff)]
    == $past(word_w) && dc_meta_mem[$past(set)][DC_AGE_W + $past(d_hidx) % DC_WAYS])
    else $error("store hit not written or not dirty");
  a_no_locked_vic: assert property (r.fsm == L1C_LOOK && !none
    |-> !(r.sel ? dc_lck[dc_vic[DC_AW-1:0]] : ic_lck[ic_vic[IC_AW-1:0]]))
    else $error("locked way chosen as victim");
  a_all_locked: assert property (r.fsm == L1C_LOOK && !lfb_path && !hit && none
    && r.req.op != L1C_OP_UNLOCK |=> !r.alloc && bus_req_o.valid)
    else $error("fully locked set allocated");
  a_dirty_wback: assert property (r.fsm == L1C_LOOK && !hit && !none && vdirty
    && r.req.op != L1C_OP_UNLOCK |=> r.fsm == L1C_WBACK && bus_req_o.we)
    else $error("dirty victim not written back");

  c_ifill: cover property (r.fsm == L1C_FILL && r.sel == SEL_I && bus_ack_i && r.beat == LAST_BEAT);
  c_wback: cover property (r.fsm == L1C_WBACK && bus_ack_i && r.beat == LAST_BEAT);
  c_bypass: cover property (r.fsm == L1C_LOOK && lfb_path);
  c_noalloc: cover property (r.fsm == L1C_FILL && !r.alloc && bus_ack_i);

endmodule : l1c_top
`default_nettype wire

// >>> testbench/l1c_bus_model.sv
// System bus memory model on the far side of the split L1 caches.
// Assumes one beat per request, acked prompt or after three waits.
`timescale 1ns/1ps
`default_nettype none
module l1c_bus_model
  import l1c_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Bus from the caches
  input wire l1c_bus_t bus_req_i,
  input wire logic slow_i,
  output logic bus_ack_o,
  output logic [31:0] bus_rdata_o,
  // Traffic record
  output logic [7:0] n_rd_o,
  output logic [7:0] n_wr_o,
  output logic [31:0] wr_addr_o,
  output logic [31:0] wr_data_o
);
  logic [1:0] wait_r;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_ack_o <= 1'b0;
      bus_rdata_o <= 32'h0;
      wait_r <= 2'h0;
      n_rd_o <= 8'h0;
      n_wr_o <= 8'h0;
      wr_addr_o <= 32'h0;
      wr_data_o <= 32'h0;
    end else if (bus_ack_o) begin
      // Released data turns over so a stale sample shows
      bus_ack_o <= 1'b0;
      bus_rdata_o <= ~bus_rdata_o;
    end else if (bus_req_i.valid && wait_r >= (slow_i ? 2'h3 : 2'h0)) begin
      bus_ack_o <= 1'b1;
      wait_r <= 2'h0;
      bus_rdata_o <= bus_req_i.addr ^ 32'h5a5a_0000;
      if (bus_req_i.we) begin
        n_wr_o <= n_wr_o + 8'h1;
        wr_addr_o <= bus_req_i.addr;
        wr_data_o <= bus_req_i.wdata;
      end else begin
        n_rd_o <= n_rd_o + 8'h1;
      end
    end else begin
      if (bus_req_i.valid) begin
        wait_r <= wait_r + 2'h1;
      end
      bus_rdata_o <= ~bus_rdata_o;
    end
  end
endmodule : l1c_bus_model
`default_nettype wire

// >>> testbench/test_l1_split_cache_with_locking.sv
// Self-checking bench for the split L1 caches with line locking.
// Assumes the bus model answers reads with address xor 5a5a0000.
`timescale 1ns/1ps
`default_nettype none
module test_l1_split_cache_with_locking
  import l1c_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic slow = 1'b0;
  l1c_req_t i_req = '0;
  l1c_req_t d_req = '0;
  logic i_ready_o, d_ready_o, bus_ack;
  l1c_rsp_t i_rsp_o, d_rsp_o;
  l1c_bus_t bus_req;
  logic [31:0] bus_rdata, wr_addr, wr_data;
  logic [7:0] n_rd, n_wr;
  int n_errors = 0;
  int n_tests = 0;

  always #10 ref_clk_i = ~ref_clk_i;

  l1c_top DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .i_req_i(i_req), .i_ready_o(i_ready_o),
    .i_rsp_o(i_rsp_o), .d_req_i(d_req), .d_ready_o(d_ready_o), .d_rsp_o(d_rsp_o),
    .bus_req_o(bus_req), .bus_ack_i(bus_ack), .bus_rdata_i(bus_rdata));

  l1c_bus_model far_bus (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus_req_i(bus_req),
    .slow_i(slow), .bus_ack_o(bus_ack), .bus_rdata_o(bus_rdata), .n_rd_o(n_rd),
    .n_wr_o(n_wr), .wr_addr_o(wr_addr), .wr_data_o(wr_data));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic acc(input logic sel, input l1c_op_t op, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] rd, output int cyc);
    l1c_req_t r;
    logic rv;
    r = '{valid: 1'b1, op: op, vaddr: a, ptag: a[31:10], wdata: wd, wstrb: 4'hf};
    if (sel) d_req = r; else i_req = r;
    cyc = 0;
    rv = 1'b0;
    while ((sel ? d_ready_o : i_ready_o) !== 1'b1) begin
      @(posedge ref_clk_i);
      #1;
    end
    @(posedge ref_clk_i);
    #1;
    if (sel) d_req.valid = 1'b0; else i_req.valid = 1'b0;
    while (rv !== 1'b1 && cyc < 100) begin
      cyc++;
      rv = sel ? d_rsp_o.valid : i_rsp_o.valid;
      rd = sel ? d_rsp_o.rdata : i_rsp_o.rdata;
      if (rv !== 1'b1) begin
        @(posedge ref_clk_i);
        #1;
      end
    end
    if (rv !== 1'b1) chk("answer", 32'h1, 32'h0);
  endtask : acc

  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_fetch();
    logic [31:0] rd;
    logic [7:0] r0;
    int cyc;
    slow = 1'b1;
    r0 = n_rd;
    acc(SEL_I, L1C_OP_LOAD, 32'h0000_1238, 32'h0, rd, cyc);
    chk("fetch miss data", 32'h5a5a_1238, rd);
    slow = 1'b0;
    acc(SEL_I, L1C_OP_LOAD, 32'h0000_123c, 32'h0, rd, cyc);
    chk("fetch hit data", 32'h5a5a_123c, rd);
    chk("fetch hit cycles", 32'h2, 32'(cyc));
    chk("fetch fill reads", 32'h4, 32'(n_rd - r0));
    $display("test fetch done");
  endtask : t_fetch

  task automatic t_lock();
    logic [31:0] rd;
    logic [7:0] r0, w0;
    int cyc;
    for (int k = 0; k < 4; k++) begin
      acc(SEL_D, L1C_OP_LOCK, 32'h0000_0100 + 32'(k) * 32'h400, 32'h0, rd, cyc);
    end
    r0 = n_rd;
    w0 = n_wr;
    acc(SEL_D, L1C_OP_STORE, 32'h0000_050c, 32'hcafe_f00d, rd, cyc);
    acc(SEL_D, L1C_OP_LOAD, 32'h0000_050c, 32'h0, rd, cyc);
    chk("locked store hit", 32'hcafe_f00d, rd);
    chk("locked hit traffic", 32'h0, 32'(n_rd - r0) | 32'(n_wr - w0));
    $display("test lock done");
  endtask : t_lock

  task automatic t_full();
    logic [31:0] rd;
    logic [7:0] r0, w0;
    int cyc;
    r0 = n_rd;
    w0 = n_wr;
    acc(SEL_D, L1C_OP_STORE, 32'h0000_1100, 32'h1234_5678, rd, cyc);
    chk("thru writes", 32'h1, 32'(n_wr - w0));
    chk("thru addr", 32'h0000_1100, wr_addr);
    chk("thru data", 32'h1234_5678, wr_data);
    acc(SEL_D, L1C_OP_LOAD, 32'h0000_1100, 32'h0, rd, cyc);
    chk("no alloc load", 32'h5a5a_1100, rd);
    acc(SEL_D, L1C_OP_LOAD, 32'h0000_0100, 32'h0, rd, cyc);
    chk("locked kept", 32'h5a5a_0100, rd);
    chk("full set reads", 32'h4, 32'(n_rd - r0));
    $display("test full set done");
  endtask : t_full

  task automatic t_evict();
    logic [31:0] rd;
    logic [7:0] r0, w0;
    int cyc;
    acc(SEL_D, L1C_OP_UNLOCK, 32'h0000_0500, 32'h0, rd, cyc);
    r0 = n_rd;
    w0 = n_wr;
    acc(SEL_D, L1C_OP_LOAD, 32'h0000_1500, 32'h0, rd, cyc);
    chk("evict load", 32'h5a5a_1500, rd);
    acc(SEL_D, L1C_OP_LOAD, 32'h0000_1504, 32'h0, rd, cyc);
    chk("evict writes", 32'h4, 32'(n_wr - w0));
    chk("victim addr", 32'h0000_050c, wr_addr);
    chk("dirty data", 32'hcafe_f00d, wr_data);
    chk("evict reads", 32'h4, 32'(n_rd - r0));
    $display("test evict done");
  endtask : t_evict

  // Fill buffer was dropped by the data misses, so these hit the array
  task automatic t_icache();
    logic [31:0] rd;
    logic [7:0] r0;
    int cyc;
    r0 = n_rd;
    acc(SEL_I, L1C_OP_LOCK, 32'h0000_1230, 32'h0, rd, cyc);
    chk("ilock answer", 32'h0, rd);
    acc(SEL_I, L1C_OP_LOAD, 32'h0000_1234, 32'h0, rd, cyc);
    chk("icache hit data", 32'h5a5a_1234, rd);
    chk("icache hit cycles", 32'h2, 32'(cyc));
    acc(SEL_I, L1C_OP_UNLOCK, 32'h0000_1230, 32'h0, rd, cyc);
    chk("icache hit reads", 32'h0, 32'(n_rd - r0));
    $display("test icache done");
  endtask : t_icache

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge ref_clk_i);
    #1;
    rst_i = 1'b0;
    t_fetch();
    t_lock();
    t_full();
    t_evict();
    t_icache();
    summarize();
  end

  initial begin
    #200000;
    n_errors++;
    summarize();
  end
endmodule : test_l1_split_cache_with_locking
`default_nettype wire
